// [logic/cmpctl_top.sv]
// Dual comparator control block with APB register access.
// Assumes raw comparator outputs are asynchronous and the timer clock
// inputs are sampled levels synchronous to pclk.
`timescale 1ns/1ps

// Operation
// - Control bit 7 switches the comparator on; clear disables it.
// - While off, every positive and negative input selection is released.
// - Result is one when positive input exceeds negative; bit 4 inverts.
// - Bit 5 drives result to pin when direction bit clear, regardless of on.
// - Bit 2 selects fast normal power when set; resets to one.
// - Bit 1 enables input hysteresis; read-write, resets to zero.
// - Bit 0 makes timer and pin output change on timer clock fall.
// - With prescaler in use, latch clock is the prescaler output.
// - Latch on falling timer edge; the timer counts on rising.
// - Rising and falling detectors with enables set the interrupt flag.
// - Second register bit 7 lets rising transitions set the flag.
// - Second register bit 6 lets falling transitions set the flag.
// - Only software clears the flag; a same-cycle edge keeps it set.
// - Request needs flag, comparator, peripheral and global enables.
// - Toggling polarity or on bit while off can set the flag.
// - Positive field: pin, reference converter, fixed reference, ground.
// - Negative field: four shared pins, fixed reference, rest reserved.
// - Result is sampled once per cycle for status and edges.
// - While off the comparator output equals the polarity bit 4.
// - Mirror register holds comparator one in bit 0, two in bit 1.
module cmpctl_top
    import cmpctl_pkg::*;
#(
    parameter int NUM_CMP = 2,
    parameter int ADDR_W  = 8
)
(
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [ADDR_W-1:0]          paddr,
    input  wire logic [31:0]                pwdata,
    input  wire logic [3:0]                 pstrb,
    output logic [31:0]                     prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic [NUM_CMP-1:0]         raw_result,
    input  wire logic                       timer_clk,
    input  wire logic                       prescaled_clk,
    input  wire logic                       prescaler_in_use,
    input  wire logic [NUM_CMP-1:0]         pin_direction_bit,
    output logic [NUM_CMP-1:0]              result_pin_out,
    output logic [NUM_CMP-1:0]              result_pin_oe,
    output logic [NUM_CMP-1:0]              timer_gate_out,
    output logic [NUM_CMP-1:0]              speed_power_sel,
    output logic [NUM_CMP-1:0]              hysteresis_on,
    output logic [NUM_CMP-1:0]              analog_enable,
    output logic [NUM_CMP*CMPCTL_POS_W-1:0] positive_sel,
    output logic [NUM_CMP*CMPCTL_NEG_W-1:0] negative_sel,
    output logic                            irq_request
);

    // The register map has room for exactly two channels.
    if (NUM_CMP != 2)
    begin : g_bad_num
        $error("cmpctl_top supports exactly two comparators");
    end
    if (ADDR_W < 5)
    begin : g_bad_addr
        $error("cmpctl_top needs at least five address bits");
    end

    logic [7:0]         ctl_r [NUM_CMP];
    logic [7:0]         sel_r [NUM_CMP];
    logic [NUM_CMP-1:0] flag_r;
    logic [NUM_CMP-1:0] flag_nxt;
    logic [NUM_CMP-1:0] irq_en_r;
    logic [7:0]         core_r;
    logic [31:0]        prdata_r;
    logic [31:0]        rd_nxt;
    logic               err_r;
    logic               err_nxt;
    logic               tclk_prev_r;
    logic               tclk_cur;
    logic               tclk_fall;
    logic [NUM_CMP-1:0] result_w;
    logic [NUM_CMP-1:0] rise_w;
    logic [NUM_CMP-1:0] fall_w;
    logic [NUM_CMP-1:0] sync_w;
    logic [NUM_CMP-1:0] edge_set;
    logic [NUM_CMP-1:0] flag_clr;
    logic               setup_ph;
    logic               wr_take;
    logic               wr_lane0;
    logic [7:0]         wbyte;
    logic [7:0]         ofs;
    logic               hit;

    // Register decode helpers, shared by the read and write paths.
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == CMPCTL_OFS_CTL1)   || (a == CMPCTL_OFS_SEL1)   ||
                    (a == CMPCTL_OFS_CTL2)   || (a == CMPCTL_OFS_SEL2)   ||
                    (a == CMPCTL_OFS_MIRROR) || (a == CMPCTL_OFS_FLAG)   ||
                    (a == CMPCTL_OFS_IRQ_EN) || (a == CMPCTL_OFS_CORE_IRQ);
    endfunction

    function automatic logic [7:0] ctl_ofs(input int idx);
        ctl_ofs = (idx == 0) ? CMPCTL_OFS_CTL1 : CMPCTL_OFS_CTL2;
    endfunction

    function automatic logic [7:0] sel_ofs(input int idx);
        sel_ofs = (idx == 0) ? CMPCTL_OFS_SEL1 : CMPCTL_OFS_SEL2;
    endfunction

    // APB decode. Reads are captured at setup, so the access phase
    // always completes in one cycle with registered data.
    assign ofs      = (ADDR_W > 8) ? paddr[7:0] : 8'(paddr);
    assign hit      = is_mapped(ofs) && (paddr >> 8 == '0);
    assign setup_ph = psel & ~penable;
    assign wr_take  = psel & penable & pwrite & hit;
    assign wr_lane0 = wr_take & pstrb[0];
    assign wbyte    = pwdata[7:0];
    assign pready   = 1'b1;
    assign prdata   = prdata_r;
    assign pslverr  = psel & penable & err_r;

    // Timer latch clock: prescaler output when the prescaler is in use.
    assign tclk_cur  = prescaler_in_use ? prescaled_clk : timer_clk;
    assign tclk_fall = tclk_prev_r & ~tclk_cur;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tclk_prev_r <= 1'b0;
        end
        else
        begin
            tclk_prev_r <= tclk_cur;
        end
    end

    genvar gi;
    for (gi = 0; gi < NUM_CMP; gi++)
    begin : g_cmp
        logic ctl_we;
        logic sel_we;

        assign ctl_we = wr_lane0 && (ofs == ctl_ofs(gi));
        assign sel_we = wr_lane0 && (ofs == sel_ofs(gi));

        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                ctl_r[gi] <= CMPCTL_CTL_RST;
                sel_r[gi] <= CMPCTL_SEL_RST;
            end
            else
            begin
                if (ctl_we)
                begin
                    ctl_r[gi] <= wbyte & CMPCTL_CTL_WMASK;
                end
                if (sel_we)
                begin
                    sel_r[gi] <= wbyte & CMPCTL_SEL_WMASK;
                end
            end
        end

        cmpctl_chan u_chan (
            .pclk              (pclk),
            .presetn           (presetn),
            .raw_in            (raw_result[gi]),
            .comparator_on     (ctl_r[gi][CMPCTL_B_ON]),
            .result_invert     (ctl_r[gi][CMPCTL_B_INVERT]),
            .timer_sync_sel    (ctl_r[gi][CMPCTL_B_SYNC]),
            .pos_code          (sel_r[gi][CMPCTL_B_PCH_LO +: 2]),
            .neg_code          (sel_r[gi][CMPCTL_B_NCH_LO +: 3]),
            .tclk_fall         (tclk_fall),
            .comparator_result (result_w[gi]),
            .rise_evt          (rise_w[gi]),
            .fall_evt          (fall_w[gi]),
            .sync_result       (sync_w[gi]),
            .positive_sel      (positive_sel[gi*CMPCTL_POS_W +:
                                             CMPCTL_POS_W]),
            .negative_sel      (negative_sel[gi*CMPCTL_NEG_W +:
                                             CMPCTL_NEG_W])
        );

        // Edge enables qualify each detector separately.
        assign edge_set[gi] =
            (rise_w[gi] & sel_r[gi][CMPCTL_B_RISE_EN]) |
            (fall_w[gi] & sel_r[gi][CMPCTL_B_FALL_EN]);

        // The pin override ignores the on bit; the pad needs its
        // direction bit clear before it really drives.
        assign result_pin_oe[gi]  = ctl_r[gi][CMPCTL_B_DRIVE] &
                                    ~pin_direction_bit[gi];
        assign result_pin_out[gi] = sync_w[gi];
        assign timer_gate_out[gi] = sync_w[gi];
        assign speed_power_sel[gi] = ctl_r[gi][CMPCTL_B_SPEED];
        assign hysteresis_on[gi]   = ctl_r[gi][CMPCTL_B_HYST];
        assign analog_enable[gi]   = ctl_r[gi][CMPCTL_B_ON];
    end

    // Flags clear by writing one. Set beats clear so no edge is lost.
    assign flag_clr = (wr_lane0 && ofs == CMPCTL_OFS_FLAG) ?
                      wbyte[NUM_CMP-1:0] : '0;
    assign flag_nxt = (flag_r & ~flag_clr) | edge_set;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flag_r   <= '0;
            irq_en_r <= '0;
            core_r   <= '0;
        end
        else
        begin
            flag_r <= flag_nxt;
            if (wr_lane0 && ofs == CMPCTL_OFS_IRQ_EN)
            begin
                irq_en_r <= wbyte[NUM_CMP-1:0];
            end
            if (wr_lane0 && ofs == CMPCTL_OFS_CORE_IRQ)
            begin
                core_r <= wbyte & CMPCTL_CORE_WMASK;
            end
        end
    end

    // The flag and all three enables must agree before the processor is asked.
    assign irq_request = (|(flag_r & irq_en_r)) &
                         core_r[CMPCTL_B_PERIPHERAL_IRQ_EN] &
                         core_r[CMPCTL_B_GIE];

    // Read multiplexer; unmapped addresses read zero with an error.
    always_comb
    begin
        rd_nxt = 32'h0000_0000;
        case (ofs)
            CMPCTL_OFS_CTL1:
            begin
                rd_nxt[7:0] = ctl_r[0];
                rd_nxt[CMPCTL_B_RESULT] = result_w[0];
            end
            CMPCTL_OFS_CTL2:
            begin
                rd_nxt[7:0] = ctl_r[1];
                rd_nxt[CMPCTL_B_RESULT] = result_w[1];
            end
            CMPCTL_OFS_SEL1:
            begin
                rd_nxt[7:0] = sel_r[0];
            end
            CMPCTL_OFS_SEL2:
            begin
                rd_nxt[7:0] = sel_r[1];
            end
            CMPCTL_OFS_MIRROR:
            begin
                rd_nxt[NUM_CMP-1:0] = result_w;
            end
            CMPCTL_OFS_FLAG:
            begin
                rd_nxt[NUM_CMP-1:0] = flag_r;
            end
            CMPCTL_OFS_IRQ_EN:
            begin
                rd_nxt[NUM_CMP-1:0] = irq_en_r;
            end
            CMPCTL_OFS_CORE_IRQ:
            begin
                rd_nxt[7:0] = core_r;
            end
            default:
            begin
                rd_nxt = 32'h0000_0000;
            end
        endcase
        if (!hit)
        begin
            rd_nxt = 32'h0000_0000;
        end
    end

    assign err_nxt = setup_ph ? ~hit : err_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r <= 32'h0000_0000;
            err_r    <= 1'b0;
        end
        else
        begin
            err_r <= err_nxt;
            if (setup_ph && !pwrite)
            begin
                prdata_r <= rd_nxt;
            end
        end
    end

endmodule

// [logic/cmpctl_pkg.sv]
// Package for the dual comparator control block: register map, field
// positions, reset values and input selection codes.
// Assumes a 32-bit APB slave with one aligned word per register.
package cmpctl_pkg;

    // Register byte offsets.
    localparam logic [7:0] CMPCTL_OFS_CTL1     = 8'h00;
    localparam logic [7:0] CMPCTL_OFS_SEL1     = 8'h04;
    localparam logic [7:0] CMPCTL_OFS_CTL2     = 8'h08;
    localparam logic [7:0] CMPCTL_OFS_SEL2     = 8'h0C;
    localparam logic [7:0] CMPCTL_OFS_MIRROR   = 8'h10;
    localparam logic [7:0] CMPCTL_OFS_FLAG     = 8'h14;
    localparam logic [7:0] CMPCTL_OFS_IRQ_EN   = 8'h18;
    localparam logic [7:0] CMPCTL_OFS_CORE_IRQ = 8'h1C;

    // Field positions of comparator_control.
    localparam int CMPCTL_B_ON     = 7;
    localparam int CMPCTL_B_RESULT = 6;
    localparam int CMPCTL_B_DRIVE  = 5;
    localparam int CMPCTL_B_INVERT = 4;
    localparam int CMPCTL_B_SPEED  = 2;
    localparam int CMPCTL_B_HYST   = 1;
    localparam int CMPCTL_B_SYNC   = 0;

    // Field positions of comparator_input_and_edge_select.
    localparam int CMPCTL_B_RISE_EN = 7;
    localparam int CMPCTL_B_FALL_EN = 6;
    localparam int CMPCTL_B_PCH_LO  = 4;
    localparam int CMPCTL_B_NCH_LO  = 0;

    // Field positions of core_irq_control.
    localparam int CMPCTL_B_GIE  = 7;
    localparam int CMPCTL_B_PERIPHERAL_IRQ_EN = 6;

    // Writable masks; bit 3 and the result bit never store a value.
    localparam logic [7:0] CMPCTL_CTL_WMASK = 8'hB7;
    localparam logic [7:0] CMPCTL_SEL_WMASK = 8'hF7;
    localparam logic [7:0] CMPCTL_CORE_WMASK = 8'hC0;

    // Reset values.
    localparam logic [7:0] CMPCTL_CTL_RST = 8'h04;
    localparam logic [7:0] CMPCTL_SEL_RST = 8'h00;

    // Positive channel codes.
    typedef enum logic [1:0] {
        CMPCTL_PCH_PIN = 2'h0,
        CMPCTL_PCH_DAC = 2'h1,
        CMPCTL_PCH_FIX = 2'h2,
        CMPCTL_PCH_GND = 2'h3
    } cmpctl_pch_t;

    // Negative channel codes; 5 to 7 are reserved.
    localparam logic [2:0] CMPCTL_NCH_FIX = 3'h4;

    localparam int CMPCTL_POS_W = 4;
    localparam int CMPCTL_NEG_W = 5;

endpackage

// [logic/cmpctl_chan.sv]
// One comparator channel: synchroniser, sampling, edge detection, timer
// latch and input multiplexer decode.
// Assumes the top supplies decoded controls and a timer falling strobe.
`timescale 1ns/1ps
module cmpctl_chan
    import cmpctl_pkg::*;
(
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    raw_in,
    input  wire logic                    comparator_on,
    input  wire logic                    result_invert,
    input  wire logic                    timer_sync_sel,
    input  wire logic [1:0]              pos_code,
    input  wire logic [2:0]              neg_code,
    input  wire logic                    tclk_fall,
    output logic                         comparator_result,
    output logic                         rise_evt,
    output logic                         fall_evt,
    output logic                         sync_result,
    output logic [CMPCTL_POS_W-1:0]      positive_sel,
    output logic [CMPCTL_NEG_W-1:0]      negative_sel
);

    logic meta_r;
    logic stable_r;
    logic result_r;
    logic prev_r;
    logic latch_r;
    logic result_nxt;
    logic latch_nxt;

    // The first stage is read only by the second.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_r   <= 1'b0;
            stable_r <= 1'b0;
        end
        else
        begin
            meta_r   <= raw_in;
            stable_r <= meta_r;
        end
    end

    // Off forces zero before inversion, so polarity still reaches edges.
    assign result_nxt = (comparator_on & stable_r)
                        ^ result_invert;
    assign latch_nxt  = tclk_fall ? result_r : latch_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            result_r <= 1'b0;
            prev_r   <= 1'b0;
            latch_r  <= 1'b0;
        end
        else
        begin
            result_r <= result_nxt;
            prev_r   <= result_r;
            latch_r  <= latch_nxt;
        end
    end

    assign comparator_result = result_r;
    assign rise_evt    = result_r & ~prev_r;
    assign fall_evt    = ~result_r & prev_r;
    assign sync_result = timer_sync_sel ? latch_r : result_r;

    // Every source is released while the comparator is off.
    assign positive_sel = comparator_on ?
                          CMPCTL_POS_W'(1) << pos_code : '0;
    assign negative_sel = (comparator_on && neg_code <= CMPCTL_NCH_FIX) ?
                          CMPCTL_NEG_W'(1) << neg_code : '0;

endmodule

// [dv/cmpctl_analog_model.sv]
// Model of the analog comparator cores and the timer clock source.
// Assumes the bench sets the analog relation and starts or stops clocks.
`timescale 1ns/1ps
module cmpctl_analog_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [1:0] above,
    input  wire logic [1:0] powered,
    input  wire logic       run_t,
    input  wire logic       run_p,
    output logic [1:0]      raw_result,
    output logic            timer_clk,
    output logic            prescaled_clk
);
    logic [1:0] tdiv_r;
    logic [3:0] pdiv_r;
    logic [1:0] junk_r;
    // An unpowered core gives no valid answer, so it shows a moving pattern.
    assign raw_result    = (powered & above) | (~powered & junk_r);
    assign timer_clk     = tdiv_r[1];
    assign prescaled_clk = pdiv_r[3];
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tdiv_r <= 2'h0;
            pdiv_r <= 4'h0;
            junk_r <= 2'h1;
        end
        else
        begin
            tdiv_r <= tdiv_r + 2'(run_t);
            pdiv_r <= pdiv_r + 4'(run_p);
            junk_r <= ~junk_r;
        end
    end
endmodule

// [dv/cmpctl_asserts.sv]
// Property checker for the comparator block, bound to its top ports.
// Assumes one clock domain with an active-low asynchronous reset.
`timescale 1ns/1ps
module cmpctl_asserts
    import cmpctl_pkg::*;
#(
    parameter int NUM_CMP = 2,
    parameter int ADDR_W  = 8
)
(
    input wire logic                       pclk,
    input wire logic                       presetn,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [ADDR_W-1:0]          paddr,
    input wire logic [31:0]                pwdata,
    input wire logic [3:0]                 pstrb,
    input wire logic [31:0]                prdata,
    input wire logic [NUM_CMP-1:0]         pin_direction_bit,
    input wire logic [NUM_CMP-1:0]         result_pin_out,
    input wire logic [NUM_CMP-1:0]         result_pin_oe,
    input wire logic [NUM_CMP-1:0]         timer_gate_out,
    input wire logic [NUM_CMP-1:0]         speed_power_sel,
    input wire logic [NUM_CMP-1:0]         hysteresis_on,
    input wire logic [NUM_CMP-1:0]         analog_enable,
    input wire logic [NUM_CMP*CMPCTL_POS_W-1:0] positive_sel,
    input wire logic [NUM_CMP*CMPCTL_NEG_W-1:0] negative_sel
);
    wire rd_acc  = psel && penable && !pwrite;
    wire wr_acc  = psel && penable && pwrite && pstrb[0];
    wire wr_ctl1 = wr_acc && paddr == CMPCTL_OFS_CTL1;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_on_bit;
        wr_ctl1 |=> analog_enable[0] == $past(pwdata[CMPCTL_B_ON]);
    endproperty
    a_on_bit: assert property (p_on_bit)
        else $error("on bit not applied");
    property p_off_release;
        !analog_enable[0] && $past(!analog_enable[0])
            |-> positive_sel[3:0] == '0 && negative_sel[4:0] == '0;
    endproperty
    a_off_release: assert property (p_off_release)
        else $error("input selected while off");
    property p_pos_onehot;
        analog_enable[0] && $past(analog_enable[0])
            |-> $onehot(positive_sel[3:0]);
    endproperty
    a_pos_onehot: assert property (p_pos_onehot)
        else $error("positive select not one-hot");
    property p_neg_onehot;
        $onehot0(negative_sel[4:0]) && $onehot0(negative_sel[9:5]);
    endproperty
    a_neg_onehot: assert property (p_neg_onehot)
        else $error("negative select has several bits");
    property p_pin_dir;
        (result_pin_oe & pin_direction_bit) == '0;
    endproperty
    a_pin_dir: assert property (p_pin_dir)
        else $error("pin driven while direction is input");
    property p_reset_vals;
        $rose(presetn) |-> speed_power_sel == 2'b11 && hysteresis_on == '0;
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("speed or hysteresis reset value wrong");
    property p_gap_bit;
        rd_acc && paddr[1:0] == 2'b00 && paddr < 8'h10
            |-> prdata[3] == 1'b0 && prdata[31:8] == '0;
    endproperty
    a_gap_bit: assert property (p_gap_bit)
        else $error("unimplemented control bit reads one");
    property p_mirror_w;
        rd_acc && paddr == CMPCTL_OFS_MIRROR |-> prdata[31:2] == '0;
    endproperty
    a_mirror_w: assert property (p_mirror_w)
        else $error("mirror register upper bits set");
    property p_gate_pin;
        timer_gate_out == result_pin_out;
    endproperty
    a_gate_pin: assert property (p_gate_pin)
        else $error("timer and pin outputs differ");
endmodule

bind cmpctl_top cmpctl_asserts #(.NUM_CMP(NUM_CMP), .ADDR_W(ADDR_W))
    u_cmpctl_asserts (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pin_direction_bit(pin_direction_bit),
    .result_pin_out(result_pin_out), .result_pin_oe(result_pin_oe),
    .timer_gate_out(timer_gate_out), .speed_power_sel(speed_power_sel),
    .hysteresis_on(hysteresis_on), .analog_enable(analog_enable),
    .positive_sel(positive_sel), .negative_sel(negative_sel));

// [dv/tb_cmpctl_top.sv]
// Self-checking bench for the comparator block.
// Drives APB and the analog model; the slave answers with no wait state.
`timescale 1ns/1ps
module tb_cmpctl_top;
    import cmpctl_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0]  pstrb = 4'hF;
    logic        use_pre = 1'b0;
    logic        run_t = 1'b0;
    logic        run_p = 1'b0;
    logic [1:0]  dir = 2'b11;
    logic [1:0]  above = 2'b00;
    logic [7:0]  seed = 8'h21;
    logic [31:0] prdata, rdat;
    logic        pready, pslverr, tclk, pclk_div, irq, rerr;
    logic [1:0]  raw, pin_out, pin_oe, gate, speed, hyst, aen;
    logic [7:0]  pos_sel;
    logic [9:0]  neg_sel;
    int          err_total = 0;
    int          checks = 0;

    always #25 pclk = ~pclk;

    cmpctl_top u_cmpctl_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .raw_result(raw), .timer_clk(tclk), .prescaled_clk(pclk_div),
        .prescaler_in_use(use_pre), .pin_direction_bit(dir),
        .result_pin_out(pin_out), .result_pin_oe(pin_oe),
        .timer_gate_out(gate), .speed_power_sel(speed),
        .hysteresis_on(hyst), .analog_enable(aen), .positive_sel(pos_sel),
        .negative_sel(neg_sel), .irq_request(irq));
    cmpctl_analog_model u_cmpctl_analog_model (.pclk(pclk),
        .presetn(presetn), .above(above), .powered(aen), .run_t(run_t),
        .run_p(run_p), .raw_result(raw), .timer_clk(tclk),
        .prescaled_clk(pclk_div));

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [7:0] ctl_exp(input logic [7:0] w);
        return (w & CMPCTL_CTL_WMASK) | {1'b0, w[4], 6'h00};
    endfunction
    task automatic complete_run();
        if (err_total == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // The slave never stalls, but the access phase still waits up to 16 cycles for pready.
    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [7:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            err_total++;
            $display("ERROR %0t no answer from slave", $time);
            complete_run();
        end
        @(posedge pclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 8'h00);
        chk(rdat, exp);
    endtask
    task automatic settle();
        repeat (5) @(posedge pclk);
    endtask
    task automatic pin_chk(input int cyc, input logic exp);
        repeat (cyc) @(posedge pclk);
        chk({31'h0, pin_out[0]}, {31'h0, exp});
    endtask

    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({28'h0, speed, hyst}, 32'h0000_000C);
        for (int i = 0; i < 2; i++)
        begin
            rd(8'(8 * i), 32'h0000_0004);
            rd(8'(8 * i + 4), 32'h0000_0000);
        end
        for (int k = 0; k < 12; k++)
        begin
            seed = lfsr(seed);
            apb(CMPCTL_OFS_CTL1, 1'b1, seed);
            apb(CMPCTL_OFS_SEL1, 1'b1, lfsr(seed));
            chk({29'h0, aen[0], speed[0], hyst[0]}, 32'(seed[7] * 4 + seed[2:1]));
            rd(CMPCTL_OFS_CTL1, {24'h0, ctl_exp(seed)});
            rd(CMPCTL_OFS_SEL1, {24'h0, lfsr(seed) & CMPCTL_SEL_WMASK});
        end
        pstrb <= 4'h0;
        apb(CMPCTL_OFS_SEL1, 1'b1, 8'h5A);
        pstrb <= 4'hF;
        apb(CMPCTL_OFS_MIRROR, 1'b1, 8'hFF);
        rd(CMPCTL_OFS_SEL1, {24'h0, lfsr(seed) & CMPCTL_SEL_WMASK});
        rd(CMPCTL_OFS_MIRROR, {31'h0, seed[4]});
        for (int i = 0; i < 2; i++)
        begin
            rd(i == 0 ? 8'h20 : 8'h02, 32'h0000_0000);
            chk({31'h0, rerr}, 32'h0000_0001);
        end
        apb(CMPCTL_OFS_CTL1, 1'b1, 8'h80);
        for (int p = 0; p < 4; p++)
            for (int n = 0; n < 8; n++)
            begin
                apb(CMPCTL_OFS_SEL1, 1'b1, 8'(p * 16 + n));
                chk({28'h0, pos_sel[3:0]}, 32'(1 << p));
                chk({27'h0, neg_sel[4:0]}, n < 5 ? 32'(1 << n) : 32'h0);
            end
        apb(CMPCTL_OFS_CTL1, 1'b1, 8'h00);
        chk({14'h0, pos_sel, neg_sel}, 32'h0000_0000);
        apb(CMPCTL_OFS_CTL2, 1'b1, 8'h84);
        for (int k = 0; k < 8; k++)
        begin
            seed = lfsr(seed);
            above <= seed[1:0];
            apb(CMPCTL_OFS_CTL1, 1'b1, {3'h4, seed[2], 4'h4});
            settle();
            rd(CMPCTL_OFS_MIRROR, {30'h0, seed[1], seed[0] ^ seed[2]});
        end
        above <= 2'b00;
        apb(CMPCTL_OFS_CTL1, 1'b1, 8'h84);
        apb(CMPCTL_OFS_SEL1, 1'b1, 8'h40);
        apb(CMPCTL_OFS_IRQ_EN, 1'b1, 8'h01);
        apb(CMPCTL_OFS_CORE_IRQ, 1'b1, 8'hC0);
        apb(CMPCTL_OFS_FLAG, 1'b1, 8'h03);
        above <= 2'b01;
        settle();
        rd(CMPCTL_OFS_FLAG, 32'h0);
        apb(CMPCTL_OFS_SEL1, 1'b1, 8'h80);
        above <= 2'b00;
        settle();
        rd(CMPCTL_OFS_FLAG, 32'h0);
        above <= 2'b01;
        // Clear and edge meet; set wins.
        repeat (2) @(posedge pclk);
        apb(CMPCTL_OFS_FLAG, 1'b1, 8'h01);
        rd(CMPCTL_OFS_FLAG, 32'h1);
        chk({31'h0, irq}, 32'h1);
        apb(CMPCTL_OFS_CORE_IRQ, 1'b1, 8'h80);
        chk({31'h0, irq}, 32'h0);
        apb(CMPCTL_OFS_CORE_IRQ, 1'b1, 8'h40);
        chk({31'h0, irq}, 32'h0);
        apb(CMPCTL_OFS_CORE_IRQ, 1'b1, 8'hC0);
        apb(CMPCTL_OFS_IRQ_EN, 1'b1, 8'h00);
        chk({31'h0, irq}, 32'h0);
        apb(CMPCTL_OFS_FLAG, 1'b1, 8'h00);
        rd(CMPCTL_OFS_FLAG, 32'h1);
        apb(CMPCTL_OFS_FLAG, 1'b1, 8'h01);
        rd(CMPCTL_OFS_FLAG, 32'h0);
        apb(CMPCTL_OFS_CTL1, 1'b1, 8'h00);
        settle();
        apb(CMPCTL_OFS_FLAG, 1'b1, 8'h03);
        apb(CMPCTL_OFS_CTL1, 1'b1, 8'h10);
        settle();
        rd(CMPCTL_OFS_FLAG, 32'h0000_0001);
        dir <= 2'b10;
        apb(CMPCTL_OFS_CTL1, 1'b1, 8'h30);
        settle();
        chk({28'h0, pin_oe, pin_out}, 32'h0000_0005);
        dir <= 2'b11;
        settle();
        chk({30'h0, pin_oe}, 32'h0000_0000);
        dir <= 2'b10;
        apb(CMPCTL_OFS_CTL1, 1'b1, 8'hA1);
        run_t <= 1'b1;
        pin_chk(12, 1'b1);
        run_t <= 1'b0;
        above <= 2'b00;
        pin_chk(12, 1'b1);
        run_t <= 1'b1;
        pin_chk(12, 1'b0);
        use_pre <= 1'b1;
        above <= 2'b01;
        pin_chk(12, 1'b0);
        run_p <= 1'b1;
        pin_chk(40, 1'b1);
        complete_run();
    end
endmodule
